// ==== core/bst_pkg.sv ====
package bst_pkg;
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] COUNT_ADDR = 8'h04;
	localparam logic [7:0] PERIOD_ADDR = 8'h08;
	localparam logic [7:0] STATUS_ADDR = 8'h0c;
	localparam int RUN_BIT = 15;
	localparam int IDLE_HALT_BIT = 13;
	localparam int GATE_BIT = 6;
	localparam int PRESCALE_LO = 4;
	localparam int SYNC_BIT = 2;
	localparam int SOURCE_BIT = 1;
	localparam logic [15:0] CTRL_WMASK = 16'ha076;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'hffff;
	localparam logic [7:0] DIV_WIDTH = 8'h08;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	typedef logic [1:0] bst_prescale_t;
	function automatic logic [7:0] bst_div_limit(input bst_prescale_t sel);
		case (sel)
			2'h3: bst_div_limit = 8'hff;
			2'h2: bst_div_limit = 8'h3f;
			2'h1: bst_div_limit = 8'h07;
			default: bst_div_limit = 8'h00;
		endcase
	endfunction
endpackage

// ==== core/bst_prescaler.sv ====
module bst_prescaler
	import bst_pkg::*;
(
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// Tick in, divided tick out.
	input wire logic tick_in,
	input wire logic clear,
	input wire bst_pkg::bst_prescale_t prescale_select,
	output logic tick_out
);
	logic [7:0] div_count;
	logic [7:0] next_div_count;
	logic next_tick_out;

	always_comb
	begin
		next_div_count = div_count;
		next_tick_out = 1'b0;
		if (clear)
		begin
			next_div_count = 8'h00;
		end
		else if (tick_in)
		begin
			if (div_count >= bst_div_limit(prescale_select)) // [R4]
			begin
				next_div_count = 8'h00;
				next_tick_out = 1'b1;
			end
			else
			begin
				next_div_count = div_count + 8'h01;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			div_count <= 8'h00;
			tick_out <= 1'b0;
		end
		else
		begin
			div_count <= next_div_count;
			tick_out <= next_tick_out;
		end
	end
endmodule

// ==== core/bst_timer.sv ====
// Summary of operation
// R1 - Run bit set starts the 16-bit counter; clear stops it holding value.
// R2 - Idle-halt bit set stops the timer while the device is idle.
// R3 - Gate enable ignored with external clock; internal clock counts while gate high.
// R4 - Prescale codes 11, 10, 01, 00 divide by 256, 64, 8, 1.
// R5 - Sync bit routes external input through a synchroniser; ignored on internal clock.
// R6 - Source bit set counts external pin rising edges; clear counts peripheral clock.
// R7 - Unimplemented control bits read zero and ignore writes.
// R8 - Counter increments by one per prescaled tick and wraps to zero.
module bst_timer
	import bst_pkg::*;
(
	// AHB-Lite slave.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic [1:0] hresp,
	// Device state and pins.
	input wire logic device_idle,
	input wire logic ext_count_pin,
	input wire logic gate_pin,
	// Period match pulse.
	output logic period_match
);
	import bst_pkg::*;

	logic [15:0] timer_control;
	logic [15:0] count;
	logic [15:0] period;
	logic [15:0] next_timer_control;
	logic [15:0] next_count;
	logic [15:0] next_period;
	logic wr_pend;
	logic [7:0] wr_addr;
	logic next_wr_pend;
	logic [7:0] next_wr_addr;
	logic [31:0] next_hrdata;
	logic next_period_match;
	logic ext_meta;
	logic ext_sync;
	logic ext_sync_d;
	logic ext_raw_d;
	logic gate_meta;
	logic gate_sync;
	logic pre_tick;
	logic pre_clear;
	logic count_tick;
	logic counter_run;
	logic idle_halt;
	logic gate_accumulate;
	logic ext_clock_sync;
	logic clock_source_select;
	logic enabled;
	logic ext_edge;
	logic addr_ok;

	assign counter_run = timer_control[RUN_BIT];
	assign idle_halt = timer_control[IDLE_HALT_BIT];
	assign gate_accumulate = timer_control[GATE_BIT];
	assign ext_clock_sync = timer_control[SYNC_BIT];
	assign clock_source_select = timer_control[SOURCE_BIT];

	// Both pins pass two flops; the unsynchronised mode still needs one edge
	// detector on the second stage, so it differs only by skipping the extra delay flop.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
			ext_sync_d <= 1'b0;
			ext_raw_d <= 1'b0;
			gate_meta <= 1'b0;
			gate_sync <= 1'b0;
		end
		else
		begin
			ext_meta <= ext_count_pin;
			ext_sync <= ext_meta;
			ext_sync_d <= ext_sync;
			ext_raw_d <= ext_sync_d;
			gate_meta <= gate_pin;
			gate_sync <= gate_meta;
		end
	end

	// Idle only stops the timer when software asked for it, so a timer left running keeps
	// counting while the rest of the device sleeps.
	always_comb
	begin
		enabled = counter_run && !(idle_halt && device_idle); // [R1] [R2]
		if (ext_clock_sync) // [R5]
		begin
			ext_edge = ext_sync_d && !ext_raw_d;
		end
		else
		begin
			ext_edge = ext_sync && !ext_sync_d;
		end
		if (clock_source_select) // [R6] [R3]
		begin
			pre_tick = enabled && ext_edge;
		end
		else if (gate_accumulate) // [R3]
		begin
			pre_tick = enabled && gate_sync;
		end
		else
		begin
			pre_tick = enabled;
		end
		// Clearing the prescaler on stop means a restart always begins a full division cycle.
		pre_clear = !counter_run;
	end

	// The prescaler output is registered, which adds one cycle between a tick and the count.
	bst_prescaler u_prescaler (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick_in(pre_tick),
		.clear(pre_clear),
		.prescale_select(timer_control[PRESCALE_LO +: 2]),
		.tick_out(count_tick)
	);

	// Only the four mapped words accept writes; every other address reads zero.
	// The transfer size is not decoded, because every register is one whole word.
	assign addr_ok = (haddr == CTRL_ADDR) || (haddr == COUNT_ADDR) ||
		(haddr == PERIOD_ADDR) || (haddr == STATUS_ADDR);

	always_comb
	begin
		next_wr_pend = 1'b0;
		next_wr_addr = wr_addr;
		next_hrdata = hrdata;
		next_timer_control = timer_control;
		next_period = period;
		next_count = count;
		next_period_match = 1'b0;
		// The tick is registered, so it is qualified again with the run bit: a tick that
		// leaves the prescaler as the timer stops must not move the held value.
		if (count_tick && counter_run) // [R8]
		begin
			// With the period at its reset value this compare is the wrap from the top to zero.
			if (count == period)
			begin
				next_count = COUNT_RESET;
				next_period_match = 1'b1;
			end
			else
			begin
				next_count = count + 16'h0001;
			end
		end
		// Writes land one cycle after their address phase, when the write data stands.
		// A count write in the same cycle as a tick wins, so software reads back its value.
		if (wr_pend)
		begin
			case (wr_addr)
				CTRL_ADDR: next_timer_control = hwdata[15:0] & CTRL_WMASK; // [R7]
				COUNT_ADDR: next_count = hwdata[15:0];
				PERIOD_ADDR: next_period = hwdata[15:0];
				default: next_period = period;
			endcase
		end
		// Read data is loaded at the address phase and held until the next accepted transfer.
		if (hsel && hready && htrans == HTRANS_NONSEQ)
		begin
			next_wr_pend = hwrite && addr_ok;
			next_wr_addr = haddr;
			next_hrdata = 32'h0000_0000;
			if (!hwrite)
			begin
				case (haddr)
					CTRL_ADDR: next_hrdata = {16'h0000, timer_control}; // [R7]
					COUNT_ADDR: next_hrdata = {16'h0000, count};
					PERIOD_ADDR: next_hrdata = {16'h0000, period};
					STATUS_ADDR: next_hrdata = {30'h0000_0000, enabled, count_tick};
					default: next_hrdata = 32'h0000_0000;
				endcase
			end
		end
	end

	// The slave has no wait states and no error cases; both answers still come from flops
	// so that every output of the block is registered.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			timer_control <= CTRL_RESET;
			count <= COUNT_RESET;
			period <= PERIOD_RESET;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			period_match <= 1'b0;
		end
		else
		begin
			timer_control <= next_timer_control;
			count <= next_count;
			period <= next_period;
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY;
			period_match <= next_period_match;
		end
	end
endmodule

// ==== testbench/bst_ext_src.sv ====
module bst_ext_src (
	// Count pin driven toward the timer.
	input wire logic hclk,
	output logic ext_count_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	initial ext_count_pin = 1'b0;
	// Slow edges keep every pulse visible through the synchroniser; the pin idles low.
	task automatic burst(input int n);
		repeat (n)
		begin
			@(posedge hclk) ext_count_pin <= 1'b1;
			repeat (4) @(posedge hclk);
			ext_count_pin <= 1'b0;
			repeat (4) @(posedge hclk);
		end
	endtask
endmodule

// ==== testbench/bst_timer_sva.sv ====
module bst_timer_sva
	import bst_pkg::*;
(
	// Watched ports.
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic [1:0] hresp,
	input wire logic period_match
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic acc;
	logic rd;
	assign acc = hsel && hready && htrans == HTRANS_NONSEQ;
	assign rd = acc && !hwrite;
	property p_ready; hreadyout; endproperty
	a_ready: assert property (p_ready) else $error("slave not ready");
	property p_okay; hresp == HRESP_OKAY; endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_upper; rd |=> hrdata[31:16] == 16'h0000; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_ctrl; rd && haddr == CTRL_ADDR |=> (hrdata[15:0] & ~CTRL_WMASK) == 16'h0; endproperty
	a_ctrl: assert property (p_ctrl) else $error("unused control bit set");
	property p_unmap; rd && haddr > STATUS_ADDR |=> hrdata == 32'h0; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_hold; !acc |=> $stable(hrdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_pulse; period_match |=> !period_match; endproperty
	a_pulse: assert property (p_pulse) else $error("match pulse too long");
	property p_rst; $rose(hresetn) |-> hrdata == 32'h0 && !period_match; endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
endmodule
bind bst_timer bst_timer_sva bst_timer_sva_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .period_match(period_match));

// ==== testbench/tb_basic_sixteen_bit_timer.sv ====
module tb_basic_sixteen_bit_timer;
	timeunit 1ns;
	timeprecision 1ns;
	import bst_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hready;
	logic [31:0] hrdata;
	logic hreadyout;
	logic [1:0] hresp;
	logic device_idle = 1'b0;
	logic gate_pin = 1'b0;
	logic ext_count_pin;
	logic period_match;
	logic [31:0] q;
	int n;
	int checks_done = 0;
	int miscompares = 0;
	int div[4] = '{1, 8, 64, 256};
	logic [15:0] cfg[4] = '{16'ha000, 16'h8000, 16'h8040, 16'h8040};
	assign hready = hreadyout;
	always #25 hclk = ~hclk;
	bst_timer bst_timer_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .device_idle(device_idle),
		.ext_count_pin(ext_count_pin), .gate_pin(gate_pin), .period_match(period_match));
	bst_ext_src bst_ext_src_i (.hclk(hclk), .ext_count_pin(ext_count_pin));
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		q = hrdata;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#1000000;
		miscompares++;
		end_sim();
	end
	initial
	begin
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		rchk("ctrl", CTRL_ADDR, 32'h0);
		rchk("period", PERIOD_ADDR, {16'h0, PERIOD_RESET});
		xfer(1'b1, CTRL_ADDR, 32'hffff_ffff);
		rchk("ctrl mask", CTRL_ADDR, 32'h0000_a076);
		xfer(1'b1, 8'h40, 32'hffff_ffff);
		rchk("unmapped", 8'h40, 32'h0);
		for (int p = 0; p < 4; p++)
		begin
			xfer(1'b1, COUNT_ADDR, 32'h0);
			xfer(1'b1, CTRL_ADDR, 32'h8000 | (p << 4));
			repeat (5 * div[p]) @(posedge hclk);
			xfer(1'b1, CTRL_ADDR, 32'h0);
			xfer(1'b0, COUNT_ADDR, 32'h0);
			// The run lasts 5N+2 edges and the first count lands N+1 edges after the start.
			chk("divided", q, (p == 0) ? 32'h6 : 32'h5);
			rchk("held", COUNT_ADDR, q);
		end
		for (int s = 0; s < 2; s++)
		begin
			xfer(1'b1, COUNT_ADDR, 32'h0);
			xfer(1'b1, CTRL_ADDR, 32'h8002 | (s << 2));
			// One edge first: the extra synchroniser flop delays its count by one cycle.
			fork
				bst_ext_src_i.burst(1);
				begin
					repeat (5) @(posedge hclk);
					xfer(1'b0, COUNT_ADDR, 32'h0);
				end
			join
			chk("sync delay", q, (s == 0) ? 32'h1 : 32'h0);
			bst_ext_src_i.burst(5);
			repeat (6) @(posedge hclk);
			xfer(1'b1, CTRL_ADDR, 32'h0);
			rchk("edges", COUNT_ADDR, 32'h6);
		end
		for (int k = 0; k < 4; k++)
		begin
			device_idle <= (k < 2);
			gate_pin <= (k == 3);
			xfer(1'b1, COUNT_ADDR, 32'h0);
			xfer(1'b1, CTRL_ADDR, {16'h0, cfg[k]});
			repeat (20) @(posedge hclk);
			rchk("status", STATUS_ADDR, 32'((k != 0) * 2 + k % 2));
			xfer(1'b1, CTRL_ADDR, 32'h0);
			xfer(1'b0, COUNT_ADDR, 32'h0);
			chk("gated", 32'(q != 0), 32'(k % 2));
		end
		device_idle <= 1'b0;
		xfer(1'b1, PERIOD_ADDR, 32'h3);
		xfer(1'b1, COUNT_ADDR, 32'h0);
		xfer(1'b1, CTRL_ADDR, 32'h8000);
		n = 0;
		repeat (40)
		begin
			@(posedge hclk);
			n += period_match;
		end
		chk("wraps", 32'(n >= 8 && n <= 13), 32'h1);
		xfer(1'b1, PERIOD_ADDR, {16'h0, PERIOD_RESET});
		xfer(1'b1, CTRL_ADDR, 32'h0);
		xfer(1'b1, COUNT_ADDR, 32'h0000_fffe);
		xfer(1'b1, CTRL_ADDR, 32'h8000);
		repeat (2) @(posedge hclk);
		xfer(1'b1, CTRL_ADDR, 32'h0);
		rchk("top wrap", COUNT_ADDR, 32'h1);
		end_sim();
	end
endmodule
